// ===== hw/tpms_defs.vh
/*
 * constants for the timer pin mode select block: register offsets,
 * mode field layout, reset values.
 * assumes inclusion by bare name from the hw/ design files.
 */
`ifndef TPMS_DEFS_VH
`define TPMS_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TPMS_OFS_CH0_MODE 6'h00
`define TPMS_OFS_CH0_PIN_MODE 6'h04
`define TPMS_OFS_CH1_PIN_MODE 6'h08
`define TPMS_OFS_CH2_PIN_MODE 6'h0C
`define TPMS_OFS_CH0_GEN_C 6'h10
`define TPMS_OFS_CH1_GEN_A 6'h14
`define TPMS_OFS_CH2_GEN_A 6'h18
`define TPMS_OFS_COUNTER 6'h1C
`define TPMS_OFS_PIN_STATE 6'h20

// ----------------------------------------------------------------
// mode field layout
// ----------------------------------------------------------------
`define TPMS_MODE_CAPTURE 3
`define TPMS_MODE_INIT 2
`define TPMS_MODE_ACT_HI 1
`define TPMS_MODE_ACT_LO 0
`define TPMS_ACT_OFF 2'h0
`define TPMS_ACT_LOW 2'h1
`define TPMS_ACT_HIGH 2'h2
`define TPMS_ACT_TOGGLE 2'h3
`define TPMS_BUF_A_BIT 0

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define TPMS_MODE_RESET 4'h0
`define TPMS_WORD_RESET 16'h0000
`define TPMS_RESP_OKAY 2'h0
`define TPMS_RESP_SLVERR 2'h2

`endif

// ===== hw/tpms_sync.v
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the input comes from outside aclk's domain.
 */
`timescale 1ns/1ps
module tpms_sync
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // level in and out
    input wire async_in,
    output reg sync_out
);

reg stage1;

// first stage read only by the second
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        stage1 <= 1'b0;
        sync_out <= 1'b0;
    end
    else
    begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule

// ===== hw/tpms_channel.v
/*
 * one capture/compare channel: pin output per compare action,
 * general register captured on selected pin edges.
 * assumes a synchronised pin level and a shared free counter.
 */
`timescale 1ns/1ps
`include "tpms_defs.vh"
module tpms_channel
#(
    parameter WIDTH = 16,
    parameter IGNORE_BIT2_IN_CAPTURE = 0
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire [3:0] mode,
    input wire blocked,
    input wire [WIDTH-1:0] counter,
    // software write of the general register
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    // pin
    input wire pin_level,
    output reg pin_out,
    output wire pin_oe,
    // state
    output reg [WIDTH-1:0] general_reg,
    output reg event_pulse
);

reg pin_prev;
reg [3:0] mode_prev;
wire capture = mode[`TPMS_MODE_CAPTURE];
wire [1:0] act = {mode[`TPMS_MODE_ACT_HI], mode[`TPMS_MODE_ACT_LO]};
wire rise = pin_level & ~pin_prev;
wire fall = ~pin_level & pin_prev;
wire match = ~capture & (counter == general_reg);
// bit 2 set in capture mode is a forbidden setting on channels 0 and 1: no captures
wire cap_legal = (IGNORE_BIT2_IN_CAPTURE != 0) | ~mode[`TPMS_MODE_INIT];
reg cap_edge;

// edge selection for capture
always @*
begin
    cap_edge = 1'b0;
    if (mode[`TPMS_MODE_ACT_HI])
        cap_edge = rise | fall;
    else if (!mode[`TPMS_MODE_ACT_LO])
        cap_edge = rise;
    else
        cap_edge = fall;
end

// output enabled only when compare mode with an action and not a buffer
assign pin_oe = ~blocked & ~capture & (act != `TPMS_ACT_OFF);

// pin level, capture and match handling
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        pin_prev <= 1'b0;
        mode_prev <= `TPMS_MODE_RESET;
        pin_out <= 1'b0;
        general_reg <= `TPMS_WORD_RESET;
        event_pulse <= 1'b0;
    end
    else
    begin
        pin_prev <= pin_level;
        mode_prev <= mode;
        event_pulse <= 1'b0;
        if (mode != mode_prev && !capture)
            pin_out <= mode[`TPMS_MODE_INIT];
        else if (!blocked && match)
        begin
            event_pulse <= 1'b1;
            case (act)
                `TPMS_ACT_LOW: pin_out <= 1'b0;
                `TPMS_ACT_HIGH: pin_out <= 1'b1;
                `TPMS_ACT_TOGGLE: pin_out <= ~pin_out;
                default: pin_out <= pin_out;
            endcase
        end
        // capture beats a software write in the same cycle
        if (!blocked && capture && cap_legal && cap_edge)
        begin
            general_reg <= counter;
            event_pulse <= 1'b1;
        end
        else if (wr_en)
            general_reg <= wr_data;
    end
end

endmodule

// ===== hw/tpms_top.v
/*
 * timer pin mode select: three capture/compare channels (ch0 reg c,
 * ch1 reg a, ch2 reg a) with AXI4-Lite register access.
 * assumes an AXI4-Lite master on aclk and asynchronous timer pins.
 * the counter is internal and free running, so software sees it only
 * through its read-only word; general registers are written by software
 * and overwritten by captures, a capture winning a same-cycle write.
 * pin_oe is high while a channel drives its pin; the far side must not
 * drive a pin at the same time.
 */
// What this block does
// - compare mode with action 01 drives the pin low at each match.
// - compare mode with action 10 drives the pin high at each match.
// - compare mode with action 11 inverts the pin at each match.
// - capture mode with low bits 00 captures the counter on rising pin edges.
// - capture mode with low bits 01 captures the counter on falling pin edges.
// - capture mode with bit 1 set captures on both edges; channel 2 alone ignores bit 2.
// - when channel 0 buffer mode is on, reg c makes neither capture nor compare events.
`timescale 1ns/1ps
`include "tpms_defs.vh"
module tpms_top
#(
    parameter WIDTH = 16
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // timer pins: index 0 ch0 pin c, 1 ch1 pin a, 2 ch2 pin a
    input wire [2:0] pin_in,
    output wire [2:0] pin_out,
    output wire [2:0] pin_oe,
    // channel events, one-cycle pulses
    output wire [2:0] channel_event
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [3:0] pin_mode [0:2];
reg buffer_mode_select_a;
reg [WIDTH-1:0] counter;
reg [5:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
wire [2:0] pin_sync;
wire [WIDTH-1:0] gen [0:2];
reg [2:0] gen_wr;

// ----------------------------------------------------------------
// address decode helpers
// ----------------------------------------------------------------
// word index of a byte address, used by both read and write decode
function [3:0] word_index;
    input [5:0] addr;
    begin
        word_index = addr[5:2];
    end
endfunction

// only whole aligned words are mapped; read and write refuse the rest alike
function addr_aligned;
    input [5:0] addr;
    begin
        addr_aligned = (addr[1:0] == 2'h0);
    end
endfunction

// a mode field read back as a whole word, upper bits zero
function [31:0] mode_word;
    input [3:0] mode;
    begin
        mode_word = {28'h0000000, mode};
    end
endfunction

// ----------------------------------------------------------------
// counter
// ----------------------------------------------------------------
// free running counter shared by all channels; it wraps at the top, so a
// compare value already passed is met again only a full period later
always @(posedge aclk)
begin
    if (!aresetn)
        counter <= `TPMS_WORD_RESET;
    else
        counter <= counter + {{(WIDTH-1){1'b0}}, 1'b1};
end

// ----------------------------------------------------------------
// channels
// ----------------------------------------------------------------
// only ch0 reg c can act as a buffer; the other two are never blocked
wire [2:0] chan_blocked = {2'h0, buffer_mode_select_a};
genvar g;
generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_chan
        tpms_sync u_sync
        (
            .aclk(aclk),
            .aresetn(aresetn),
            .async_in(pin_in[g]),
            .sync_out(pin_sync[g])
        );
        // channel 2 alone ignores bit 2 in capture mode
        tpms_channel #(
            .WIDTH(WIDTH),
            .IGNORE_BIT2_IN_CAPTURE(g == 2)
        ) u_chan
        (
            .aclk(aclk),
            .aresetn(aresetn),
            .mode(pin_mode[g]),
            .blocked(chan_blocked[g]),
            .counter(counter),
            .wr_en(gen_wr[g]),
            .wr_data(w_data[WIDTH-1:0]),
            .pin_level(pin_sync[g]),
            .pin_out(pin_out[g]),
            .pin_oe(pin_oe[g]),
            .general_reg(gen[g]),
            .event_pulse(channel_event[g])
        );
    end
endgenerate

// ----------------------------------------------------------------
// axi4-lite write path
// ----------------------------------------------------------------
// address and data may arrive in either order; each held until both
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
wire wr_go = aw_held & w_held & ~s_axi_bvalid;
wire [3:0] wr_idx = word_index(aw_addr);
// the counter word answers okay but is read only; the pin state word refuses writes
wire wr_mapped = addr_aligned(aw_addr) && (wr_idx <= word_index(`TPMS_OFS_COUNTER));
// a write with byte lane 0 off is answered but changes nothing
wire wr_field = wr_go & w_strb[0];

// ----------------------------------------------------------------
// write decode and register fields
// ----------------------------------------------------------------
// decode general register writes
always @*
begin
    gen_wr = 3'h0;
    if (wr_field)
    begin
        case (aw_addr)
            `TPMS_OFS_CH0_GEN_C: gen_wr[0] = 1'b1;
            `TPMS_OFS_CH1_GEN_A: gen_wr[1] = 1'b1;
            `TPMS_OFS_CH2_GEN_A: gen_wr[2] = 1'b1;
            default: gen_wr = 3'h0;
        endcase
    end
end

// hold each half of a write until the other half has arrived
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 6'h00;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
    end
    else
    begin
        // wr_go needs both halves held, so it never meets a new handshake
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
        end
        else if (wr_go)
            aw_held <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
        end
        else if (wr_go)
            w_held <= 1'b0;
    end
end

// response raised once both halves are held, kept until bready is seen
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TPMS_RESP_OKAY;
    end
    else if (wr_go)
    begin
        s_axi_bvalid <= 1'b1;
        // unaligned or unmapped writes are refused but still answered
        s_axi_bresp <= wr_mapped ? `TPMS_RESP_OKAY : `TPMS_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
end

// mode fields and buffer bit; the general registers live in the channels
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        buffer_mode_select_a <= 1'b0;
        pin_mode[0] <= `TPMS_MODE_RESET;
        pin_mode[1] <= `TPMS_MODE_RESET;
        pin_mode[2] <= `TPMS_MODE_RESET;
    end
    else if (wr_field)
    begin
        case (aw_addr)
            `TPMS_OFS_CH0_MODE: buffer_mode_select_a <= w_data[`TPMS_BUF_A_BIT];
            `TPMS_OFS_CH0_PIN_MODE: pin_mode[0] <= w_data[3:0];
            `TPMS_OFS_CH1_PIN_MODE: pin_mode[1] <= w_data[3:0];
            `TPMS_OFS_CH2_PIN_MODE: pin_mode[2] <= w_data[3:0];
            default: buffer_mode_select_a <= buffer_mode_select_a;
        endcase
    end
end

// ----------------------------------------------------------------
// axi4-lite read path
// ----------------------------------------------------------------
assign s_axi_arready = ~s_axi_rvalid;
reg [31:0] rd_word;
reg rd_ok;

// read mux over the register map
always @*
begin
    rd_word = 32'h00000000;
    rd_ok = addr_aligned(s_axi_araddr);
    // low address bits are dropped here; rd_ok turns an unaligned read into an error
    case ({word_index(s_axi_araddr), 2'h0})
        `TPMS_OFS_CH0_MODE: rd_word[`TPMS_BUF_A_BIT] = buffer_mode_select_a;
        `TPMS_OFS_CH0_PIN_MODE: rd_word = mode_word(pin_mode[0]);
        `TPMS_OFS_CH1_PIN_MODE: rd_word = mode_word(pin_mode[1]);
        `TPMS_OFS_CH2_PIN_MODE: rd_word = mode_word(pin_mode[2]);
        `TPMS_OFS_CH0_GEN_C: rd_word[WIDTH-1:0] = gen[0];
        `TPMS_OFS_CH1_GEN_A: rd_word[WIDTH-1:0] = gen[1];
        `TPMS_OFS_CH2_GEN_A: rd_word[WIDTH-1:0] = gen[2];
        `TPMS_OFS_COUNTER: rd_word[WIDTH-1:0] = counter;
        `TPMS_OFS_PIN_STATE: rd_word[5:0] = {pin_oe, pin_out};
        default: rd_ok = 1'b0;
    endcase
end

// one read at a time, answered the cycle after it is taken
// the data are latched at acceptance, so a counter read shows that edge's value
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `TPMS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `TPMS_RESP_OKAY : `TPMS_RESP_SLVERR;
    end
    else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

endmodule

// ===== tb/tpms_pin_model.sv
/* far side of the three timer pins.
   assumes the bench sets the level each pin sees while undriven. */
`timescale 1ns/1ps
module tpms_pin_model
(
    // far side levels
    input wire [2:0] drive,
    // block side
    input wire [2:0] pin_out,
    input wire [2:0] pin_oe,
    output wire [2:0] pin_in
);
    // disabled output
    // the block wins where it drives; a disabled output leaves the far side
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// ===== tb/tpms_top_sva.sv
/* checker for tpms_top: pin and event relations on ch0 and ch1.
   assumes write address and data are offered together. */
`timescale 1ns/1ps
module tpms_checker
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write side of the bus
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    // pins
    input wire [2:0] pin_in,
    input wire [2:0] pin_out,
    input wire [2:0] pin_oe,
    input wire [2:0] channel_event
);
    logic [3:0] pend;
    logic [3:0] m1;
    logic [1:0] sel;
    logic b0;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shadow ch1 mode and buffer bit; commit one edge late, as the design does
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel <= 2'h0;
            pend <= 4'h0;
            m1 <= 4'h0;
            b0 <= 1'h0;
        end
        else
        begin
            sel <= 2'h0;
            if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0])
            begin
                pend <= s_axi_wdata[3:0];
                sel <= {s_axi_awaddr == 6'h00, s_axi_awaddr == 6'h08};
            end
            if (sel[0])
                m1 <= pend;
            if (sel[1])
                b0 <= pend[0];
        end
    end
    property p_low; channel_event[1] && !m1[3] && m1[1:0] == 2'h1 |-> !pin_out[1]; endproperty
    a_low: assert property (p_low) else $error("match did not drive low");
    property p_high; channel_event[1] && !m1[3] && m1[1:0] == 2'h2 |-> pin_out[1]; endproperty
    a_high: assert property (p_high) else $error("match did not drive high");
    property p_tog; channel_event[1] && !m1[3] && m1[1:0] == 2'h3 |-> pin_out[1] != $past(pin_out[1]); endproperty
    a_tog: assert property (p_tog) else $error("match did not toggle");
    property p_rise; m1 == 4'h8 && $rose(pin_in[1]) |-> ##[1:8] channel_event[1]; endproperty
    a_rise: assert property (p_rise) else $error("rising edge not captured");
    property p_fall; m1 == 4'h9 && $fell(pin_in[1]) |-> ##[1:8] channel_event[1]; endproperty
    a_fall: assert property (p_fall) else $error("falling edge not captured");
    property p_both; m1[3:1] == 3'h5 && $changed(pin_in[1]) |-> ##[1:8] channel_event[1]; endproperty
    a_both: assert property (p_both) else $error("edge not captured in both mode");
    property p_buf; b0 && $past(b0) |-> !channel_event[0] && !pin_oe[0]; endproperty
    a_buf: assert property (p_buf) else $error("buffer mode channel active");
    property p_off; !m1[3] && m1[1:0] == 2'h0 |-> !pin_oe[1]; endproperty
    a_off: assert property (p_off) else $error("disabled output driven");
    property p_rst; $rose(aresetn) |-> pin_oe == 3'h0 && pin_out == 3'h0 && !s_axi_bvalid; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    c_cmp: cover property (channel_event[1] && !m1[3]);
    c_cap: cover property (channel_event[1] && m1[3]);
    c_buf: cover property (b0 && s_axi_bvalid);
endmodule

bind tpms_top tpms_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .pin_in, .pin_out,
    .pin_oe, .channel_event);

// ===== tb/tb_tpms_top.sv
/* bench for tpms_top: axi4-lite master tasks and scenario calls.
   assumes the pin model closes each pin loop. */
`timescale 1ns/1ps
module tb_tpms_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [2:0] drv = 3'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, c, g;
    logic [2:0] pin_in, pin_out, pin_oe, ev;
    int num_errors = 0;
    int num_checks = 0;
    int k, n;
    int tc [7] = '{1, 1, 1, 1, 1, 2, 2};
    logic [3:0] tm [7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hC, 4'hE};
    logic [1:0] te [7] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h0, 2'h2, 2'h3};
    logic [3:0] cm [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    // byte strobes tied on: every write is a whole word
    tpms_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .channel_event(ev));
    tpms_pin_model pins (.drive(drv), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    task final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // a wait that runs out counts as a mismatch and ends the run
    task give_up;
        num_errors++;
        final_report;
    endtask
    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // settle past the edge before sampling outputs
    task tick(input int t);
        repeat (t) @(posedge aclk);
        #1;
    endtask
    // write: both channels offered together, each released when taken
    task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
            if (bvalid)
                break;
        end
        bready <= 1'h0;
        check("bresp", bresp, r);
        if (i == 50)
            give_up;
    endtask
    task rd(input logic [5:0] a, output logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'h0;
            if (rvalid)
                break;
        end
        d = rdata;
        rready <= 1'h0;
        check("rresp", rresp, r);
        if (i == 50)
            give_up;
    endtask
    // count event pulses of one channel over a fixed window
    task win(input int ch, input int len, output int cnt);
        cnt = 0;
        repeat (len)
        begin
            tick(1);
            if (ev[ch] === 1'h1)
                cnt++;
        end
    endtask
    task edge1(input int ch, input logic lvl, input logic e);
        @(posedge aclk);
        drv[ch] <= lvl;
        win(ch, 12, n);
        check("edge event", n != 0, e);
    endtask
    // ch1 compare: level from bit 2 on mode write, then the match action
    task cmp1(input logic [3:0] m);
        int i;
        wr(6'h08, {28'h0, m}, 2'h0);
        tick(2);
        check("initial level", pin_out[1], m[2]);
        rd(6'h1C, c, 2'h0);
        wr(6'h14, c + 32'h28, 2'h0);
        for (i = 0; i < 100 && ev[1] !== 1'h1; i++)
            tick(1);
        check("match level", pin_out[1], m[1:0] == 2'h1 ? 1'h0 : m[1:0] == 2'h2 ? 1'h1 : !m[2]);
        if (i == 100)
            give_up;
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (k = 0; k < 9; k++)
            if (k != 7)
            begin
                rd(6'(4 * k), g, 2'h0);
                check("reset word", g, 32'h0);
            end
        rd(6'h24, g, 2'h2);
        check("unmapped data", g, 32'h0);
        wr(6'h06, 32'h1, 2'h2);
        wr(6'h18, 32'hFFFFABCD, 2'h0);
        rd(6'h18, g, 2'h0);
        check("general width", g, 32'h0000ABCD);
        for (k = 0; k < 6; k++)
            cmp1(cm[k]);
        wr(6'h08, 32'h4, 2'h0);
        tick(2);
        check("output off", pin_oe[1], 1'h0);
        // capture edges over the mode table
        for (k = 0; k < 7; k++)
        begin
            wr(6'(4 + 4 * tc[k]), {28'h0, tm[k]}, 2'h0);
            rd(6'h1C, c, 2'h0);
            edge1(tc[k], 1'h1, te[k][1]);
            rd(6'(16 + 4 * tc[k]), g, 2'h0);
            if (te[k][1])
                check("capture value", 32'(16'(g - c) < 16'h30), 32'h1);
            edge1(tc[k], 1'h0, te[k][0]);
        end
        // buffer mode on ch0 silences its register
        wr(6'h00, 32'h1, 2'h0);
        wr(6'h04, 32'h5, 2'h0);
        tick(2);
        check("buffer oe", pin_oe[0], 1'h0);
        rd(6'h1C, c, 2'h0);
        wr(6'h10, c + 32'h28, 2'h0);
        win(0, 80, n);
        check("buffer match", n, 32'h0);
        wr(6'h04, 32'h8, 2'h0);
        edge1(0, 1'h1, 1'h0);
        // buffer off again: ch0 reg c captures like the other channels
        wr(6'h00, 32'h0, 2'h0);
        rd(6'h1C, c, 2'h0);
        edge1(0, 1'h0, 1'h0);
        edge1(0, 1'h1, 1'h1);
        rd(6'h10, g, 2'h0);
        check("ch0 capture", 32'(16'(g - c) < 16'h30), 32'h1);
        final_report;
    end
endmodule
